// file: csc_defs.svh
`ifndef CSC_DEFS_SVH
`define CSC_DEFS_SVH

// Register byte offsets on the APB window
`define CSC_OFS_GROUP_ONE 8'h00
`define CSC_OFS_GROUP_TWO 8'h04
`define CSC_OFS_GROUP_THREE 8'h08
`define CSC_OFS_STATUS 8'h0c

// Reset value of every start register
`define CSC_RUN_RESET 8'h00

// Writable bit masks per register
`define CSC_WMASK_ONE 8'hff
`define CSC_WMASK_TWO 8'hff
`define CSC_WMASK_THREE 8'h01

// Field positions, first start register
`define CSC_BIT_CH_ZERO 0
`define CSC_BIT_CH_ONE_A 1
`define CSC_BIT_CH_TWO_A 2
`define CSC_BIT_CH_B_SHARED 3
`define CSC_BIT_CH_THREE 4
`define CSC_BIT_CH_FOUR 5
`define CSC_BIT_CH_FIVE 6
`define CSC_BIT_CH_TEN 7

// Field positions, second start register
`define CSC_BIT_CH_SIX_LO 0
`define CSC_BIT_CH_SIX_HI 3
`define CSC_BIT_CH_SEVEN_LO 4
`define CSC_BIT_CH_SEVEN_HI 7

// Field position, third start register
`define CSC_BIT_CH_ELEVEN 0

// Field positions, status register
`define CSC_STS_HW_STANDBY 0
`define CSC_STS_SW_STANDBY 1
`define CSC_STS_ANY_RUN 2

`endif

// file: csc_pkg.sv
package csc_pkg;

  // APB slave phase, one-hot
  typedef enum logic [1:0] {
    CSC_IDLE = 2'b01,
    CSC_ACCESS = 2'b10
  } csc_apb_state_t;

  typedef logic [7:0] csc_run_t;

endpackage

// file: csc_bank_if.sv
`timescale 1ns/1ps
// Carries one start register between the bus decoder and its bank
interface csc_bank_if;
  logic wr_en;
  logic [7:0] wr_data;
  logic clr;
  csc_pkg::csc_run_t value;

  modport ctrl (
    output wr_en,
    output wr_data,
    output clr,
    input value
  );

  modport bank (
    input wr_en,
    input wr_data,
    input clr,
    output value
  );
endinterface

// file: csc_run_bank.sv
`timescale 1ns/1ps
`include "csc_defs.svh"

// One 8-bit start register; bits outside the write mask stay zero
module csc_run_bank #(
  parameter logic [7:0] WMASK = `CSC_WMASK_ONE
) (
  input wire logic clk,
  input wire logic rst,
  csc_bank_if.bank bus
);

  // Clear wins over a write so standby entry always halts every start-bit gated channel
  always_ff @(posedge clk) begin
    if (rst || bus.clr) begin
      bus.value <= `CSC_RUN_RESET;
    end else if (bus.wr_en) begin
      bus.value <= bus.wr_data & WMASK;
    end
  end

endmodule // csc_run_bank

// file: csc_counter_start.sv
`timescale 1ns/1ps
`include "csc_defs.svh"
// Functional notes
// - First register: 8-bit R/W, channels 0-5, 10
// - Reset and either standby clear all three start registers
// - Bit 0 halts, bit 1 counts; zero initially
// - Bit 7 gates channel 10; B, H free
// - Bits 6,5,4 gate channels 5,4,3
// - Bit 3 gates channel 1B and 2B together
// - Bits 2,1,0 gate channels 2A,1A,0
// - Second register: 8-bit R/W, channels 6, 7
// - Bits 0-3 channel 6 A-D, 4-7 channel 7
// - Third register bit 0 gates channel 11
// - Third register bits 7-1 read zero

module csc_counter_start (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic HW_STANDBY,
  input wire logic SW_STANDBY,
  output logic RUN_CH_ZERO,
  output logic RUN_CH_ONE_A,
  output logic RUN_CH_ONE_B,
  output logic RUN_CH_TWO_A,
  output logic RUN_CH_TWO_B,
  output logic RUN_CH_THREE,
  output logic RUN_CH_FOUR,
  output logic RUN_CH_FIVE,
  output logic RUN_CH_TEN,
  output logic RUN_CH_TEN_FREE,
  output logic [3:0] RUN_CH_SIX,
  output logic [3:0] RUN_CH_SEVEN,
  output logic RUN_CH_ELEVEN
);

  csc_pkg::csc_apb_state_t state;
  csc_pkg::csc_apb_state_t next_state;
  logic hw_meta;
  logic hw_sync;
  logic sw_meta;
  logic sw_sync;
  logic standby;
  logic sel_one;
  logic sel_two;
  logic sel_three;
  logic sel_status;
  logic mapped;
  logic write_done;
  logic [31:0] next_rdata;

  csc_bank_if bank_one ();
  csc_bank_if bank_two ();
  csc_bank_if bank_three ();

  // Standby levels arrive from outside this clock, two flops each
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      hw_meta <= 1'b0;
      hw_sync <= 1'b0;
      sw_meta <= 1'b0;
      sw_sync <= 1'b0;
    end else begin
      hw_meta <= HW_STANDBY;
      hw_sync <= hw_meta;
      sw_meta <= SW_STANDBY;
      sw_sync <= sw_meta;
    end
  end

  assign standby = hw_sync | sw_sync;

  // Address decode; low address bits are ignored, words are aligned
  assign sel_one = (PADDR[7:2] == `CSC_OFS_GROUP_ONE >> 2);
  assign sel_two = (PADDR[7:2] == `CSC_OFS_GROUP_TWO >> 2);
  assign sel_three = (PADDR[7:2] == `CSC_OFS_GROUP_THREE >> 2);
  assign sel_status = (PADDR[7:2] == `CSC_OFS_STATUS >> 2);
  assign mapped = sel_one | sel_two | sel_three | sel_status;

  // Bus phase: setup is taken, then one access cycle with PREADY high
  always_comb begin
    next_state = state;
    unique case (state)
      csc_pkg::CSC_IDLE: begin
        if (PSEL && !PENABLE) begin
          next_state = csc_pkg::CSC_ACCESS;
        end
      end
      csc_pkg::CSC_ACCESS: begin
        next_state = csc_pkg::CSC_IDLE;
      end
      default: begin
        next_state = csc_pkg::CSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      state <= csc_pkg::CSC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // PREADY is a flop that rises for the single access cycle
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (state == csc_pkg::CSC_IDLE && PSEL && !PENABLE) begin
      PREADY <= 1'b1;
      PSLVERR <= !mapped || (PWRITE && sel_status); // Status is read-only
    end else begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // Read data, captured in setup; reserved bits are zero by construction
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (sel_one) begin
      next_rdata[7:0] = bank_one.value;
    end else if (sel_two) begin
      next_rdata[7:0] = bank_two.value;
    end else if (sel_three) begin
      next_rdata[7:0] = bank_three.value;
    end else if (sel_status) begin
      next_rdata[`CSC_STS_HW_STANDBY] = hw_sync;
      next_rdata[`CSC_STS_SW_STANDBY] = sw_sync;
      next_rdata[`CSC_STS_ANY_RUN] = |{bank_one.value, bank_two.value, bank_three.value};
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (state == csc_pkg::CSC_IDLE && PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= next_rdata;
    end else if (PREADY) begin
      PRDATA <= 32'h0000_0000; // Bus reads zero outside a read answer
    end
  end

  // Write lands at the edge that completes the access, lane 0 only
  assign write_done = (state == csc_pkg::CSC_ACCESS) && PSEL && PENABLE && PWRITE && PSTRB[0];

  assign bank_one.wr_en = write_done && sel_one;
  assign bank_one.wr_data = PWDATA[7:0];
  assign bank_one.clr = standby;
  assign bank_two.wr_en = write_done && sel_two;
  assign bank_two.wr_data = PWDATA[7:0];
  assign bank_two.clr = standby;
  // Upper bits are masked off, so a careless write cannot set them
  assign bank_three.wr_en = write_done && sel_three;
  assign bank_three.wr_data = PWDATA[7:0];
  assign bank_three.clr = standby;

  csc_run_bank #(
    .WMASK(`CSC_WMASK_ONE)
  ) u_group_one (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .bus(bank_one)
  );

  csc_run_bank #(
    .WMASK(`CSC_WMASK_TWO)
  ) u_group_two (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .bus(bank_two)
  );

  csc_run_bank #(
    .WMASK(`CSC_WMASK_THREE)
  ) u_group_three (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .bus(bank_three)
  );

  // Count enables are plain levels: dropping one freezes the counter
  // without touching its value, raising it resumes from there
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || standby) begin
      RUN_CH_ZERO <= 1'b0;
      RUN_CH_ONE_A <= 1'b0;
      RUN_CH_ONE_B <= 1'b0;
      RUN_CH_TWO_A <= 1'b0;
      RUN_CH_TWO_B <= 1'b0;
      RUN_CH_THREE <= 1'b0;
      RUN_CH_FOUR <= 1'b0;
      RUN_CH_FIVE <= 1'b0;
      RUN_CH_TEN <= 1'b0;
    end else begin
      RUN_CH_ZERO <= bank_one.value[`CSC_BIT_CH_ZERO];
      RUN_CH_ONE_A <= bank_one.value[`CSC_BIT_CH_ONE_A];
      RUN_CH_TWO_A <= bank_one.value[`CSC_BIT_CH_TWO_A];
      RUN_CH_ONE_B <= bank_one.value[`CSC_BIT_CH_B_SHARED];
      RUN_CH_TWO_B <= bank_one.value[`CSC_BIT_CH_B_SHARED];
      RUN_CH_THREE <= bank_one.value[`CSC_BIT_CH_THREE];
      RUN_CH_FOUR <= bank_one.value[`CSC_BIT_CH_FOUR];
      RUN_CH_FIVE <= bank_one.value[`CSC_BIT_CH_FIVE];
      RUN_CH_TEN <= bank_one.value[`CSC_BIT_CH_TEN];
    end
  end

  // Channel 10 event and noise counters ignore the start bit
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      RUN_CH_TEN_FREE <= 1'b0;
    end else begin
      RUN_CH_TEN_FREE <= 1'b1;
    end
  end

  // Channels 6 and 7, one enable per counter A to D
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_six_seven
      always_ff @(posedge CLK_SYS) begin
        if (SYS_RST || standby) begin
          RUN_CH_SIX[gi] <= 1'b0;
          RUN_CH_SEVEN[gi] <= 1'b0;
        end else begin
          RUN_CH_SIX[gi] <= bank_two.value[`CSC_BIT_CH_SIX_LO + gi];
          RUN_CH_SEVEN[gi] <= bank_two.value[`CSC_BIT_CH_SEVEN_LO + gi];
        end
      end
    end
  endgenerate

  // Channel 11 single counter
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || standby) begin
      RUN_CH_ELEVEN <= 1'b0;
    end else begin
      RUN_CH_ELEVEN <= bank_three.value[`CSC_BIT_CH_ELEVEN];
    end
  end

endmodule // csc_counter_start

// file: csc_counter_start_properties.sv
`timescale 1ns/1ps
// Port-level checks of the start registers and their run enables
module csc_counter_start_properties (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic HW_STANDBY,
  input wire logic SW_STANDBY,
  input wire logic RUN_CH_ZERO,
  input wire logic RUN_CH_ONE_A,
  input wire logic RUN_CH_ONE_B,
  input wire logic RUN_CH_TWO_A,
  input wire logic RUN_CH_TWO_B,
  input wire logic RUN_CH_THREE,
  input wire logic RUN_CH_FOUR,
  input wire logic RUN_CH_FIVE,
  input wire logic RUN_CH_TEN,
  input wire logic RUN_CH_TEN_FREE,
  input wire logic [3:0] RUN_CH_SIX,
  input wire logic [3:0] RUN_CH_SEVEN,
  input wire logic RUN_CH_ELEVEN
);
  logic [3:0] sb_hist;
  logic [7:0] g1;
  logic [7:0] g2;
  logic hs;
  // Recent standby would clear a register under a write, so skip those
  always_ff @(posedge CLK_SYS) begin
    sb_hist <= {sb_hist[2:0], HW_STANDBY | SW_STANDBY};
  end
  // Enables gathered in register bit order
  assign g1 = {RUN_CH_TEN, RUN_CH_FIVE, RUN_CH_FOUR, RUN_CH_THREE, RUN_CH_ONE_B, RUN_CH_TWO_A, RUN_CH_ONE_A, RUN_CH_ZERO};
  assign g2 = {RUN_CH_SEVEN, RUN_CH_SIX};
  assign hs = PSEL & PENABLE & PREADY & PWRITE & PSTRB[0] & (sb_hist == 4'h0) & ~(HW_STANDBY | SW_STANDBY);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence answer_s;
    PREADY ##1 !PREADY;
  endsequence
  ready_pulse_a: assert property (setup_s |=> answer_s) else $error("ready pulse wrong");
  wr_one_a: assert property (hs && PADDR[7:2] == 6'h00 |=> ##1 g1 == $past(PWDATA[7:0], 2))
    else $error("group one enables wrong");
  wr_two_a: assert property (hs && PADDR[7:2] == 6'h01 |=> ##1 g2 == $past(PWDATA[7:0], 2))
    else $error("group two enables wrong");
  wr_three_a: assert property (hs && PADDR[7:2] == 6'h02 |=> ##1 RUN_CH_ELEVEN == $past(PWDATA[0], 2))
    else $error("channel eleven enable wrong");
  shared_b_a: assert property (RUN_CH_ONE_B == RUN_CH_TWO_B) else $error("shared b enables differ");
  read_three_a: assert property (PREADY && !PWRITE && PADDR[7:2] == 6'h02 |-> PRDATA[31:1] == 31'h0)
    else $error("reserved bits read nonzero");
  standby_clear_a: assert property ((HW_STANDBY || SW_STANDBY) [*5] |-> {g1, g2, RUN_CH_ELEVEN} == 17'h0)
    else $error("standby left a counter running");
  reset_clear_a: assert property (disable iff (1'b0) SYS_RST [*2] |-> {g1, g2, RUN_CH_ELEVEN, RUN_CH_TEN_FREE, PREADY} == 19'h0)
    else $error("reset left an output high");
  ten_free_a: assert property (!$past(SYS_RST) |-> RUN_CH_TEN_FREE) else $error("free channel ten counters halted");
endmodule // csc_counter_start_properties

bind csc_counter_start csc_counter_start_properties chk_inst (
  .CLK_SYS, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA, .PREADY, .PSLVERR,
  .HW_STANDBY, .SW_STANDBY, .RUN_CH_ZERO, .RUN_CH_ONE_A, .RUN_CH_ONE_B, .RUN_CH_TWO_A, .RUN_CH_TWO_B,
  .RUN_CH_THREE, .RUN_CH_FOUR, .RUN_CH_FIVE, .RUN_CH_TEN, .RUN_CH_TEN_FREE, .RUN_CH_SIX, .RUN_CH_SEVEN,
  .RUN_CH_ELEVEN
);

// file: tb_top.sv
`timescale 1ns/1ps
// Drives the start registers over APB and checks the run enables
module tb_top;
  logic CLK_SYS, SYS_RST, PSEL, PENABLE, PWRITE, HW_STANDBY, SW_STANDBY, PREADY, PSLVERR, rerr;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rdat;
  logic [3:0] PSTRB, RUN_CH_SIX, RUN_CH_SEVEN;
  logic RUN_CH_ZERO, RUN_CH_ONE_A, RUN_CH_ONE_B, RUN_CH_TWO_A, RUN_CH_TWO_B, RUN_CH_THREE;
  logic RUN_CH_FOUR, RUN_CH_FIVE, RUN_CH_TEN, RUN_CH_TEN_FREE, RUN_CH_ELEVEN;
  logic [7:0] g1;
  int n_mismatch, n_tests, i;
  assign g1 = {RUN_CH_TEN, RUN_CH_FIVE, RUN_CH_FOUR, RUN_CH_THREE, RUN_CH_ONE_B, RUN_CH_TWO_A, RUN_CH_ONE_A, RUN_CH_ZERO};
  csc_counter_start csc_counter_start_inst (
    .CLK_SYS, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA, .PREADY, .PSLVERR,
    .HW_STANDBY, .SW_STANDBY, .RUN_CH_ZERO, .RUN_CH_ONE_A, .RUN_CH_ONE_B, .RUN_CH_TWO_A, .RUN_CH_TWO_B,
    .RUN_CH_THREE, .RUN_CH_FOUR, .RUN_CH_FIVE, .RUN_CH_TEN, .RUN_CH_TEN_FREE, .RUN_CH_SIX, .RUN_CH_SEVEN,
    .RUN_CH_ELEVEN
  );
  // 200 MHz clock
  initial begin
    CLK_SYS = 1'b0;
    forever #2.5 CLK_SYS = ~CLK_SYS;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; an idle cycle precedes each setup
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    PSTRB <= s;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    k = 0;
    do begin
      @(posedge CLK_SYS);
      k++;
    end while (PREADY !== 1'b1 && k < 16);
    if (k >= 16) n_mismatch++;
    rdat = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Watchdog, well beyond the less than one microsecond the tests need
  initial begin
    #50000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    {SYS_RST, PSEL, PENABLE, PWRITE, HW_STANDBY, SW_STANDBY} = 6'h20;
    {PADDR, PWDATA, PSTRB} = 44'h0;
    repeat (6) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    // Everything but the free channel 10 counters starts halted
    for (i = 0; i < 3; i++) begin
      xfer(1'b0, 8'(4 * i), 32'h0, 4'h0);
      chk(rdat, 32'h0);
    end
    chk({g1, RUN_CH_SEVEN, RUN_CH_SIX, RUN_CH_ELEVEN, RUN_CH_TEN_FREE}, 32'h1);
    // Walk one set bit through both groups, opposite directions
    for (i = 0; i < 8; i++) begin
      xfer(1'b1, 8'h00, 32'h1 << i, 4'h1);
      xfer(1'b1, 8'h04, 32'h80 >> i, 4'h1);
      xfer(1'b0, 8'h00, 32'h0, 4'h0);
      chk(rdat, 32'h1 << i);
      chk(g1, 32'h1 << i);
      chk({RUN_CH_SEVEN, RUN_CH_SIX}, 32'h80 >> i);
      chk({RUN_CH_ONE_B, RUN_CH_TWO_B}, (i == 3) ? 32'h3 : 32'h0);
    end
    // Status shows a run bit set, no standby, and a clean answer
    xfer(1'b0, 8'h0c, 32'h0, 4'h0);
    chk({rerr, rdat[30:0]}, 32'h4);
    // Third register keeps only its run bit; a write missing lane 0 is dropped
    xfer(1'b1, 8'h08, 32'hff, 4'h1);
    xfer(1'b1, 8'h08, 32'h0, 4'he);
    xfer(1'b0, 8'h08, 32'h0, 4'h0);
    chk(rdat, 32'h1);
    chk(RUN_CH_ELEVEN, 32'h1);
    // Unmapped places and status writes refuse
    xfer(1'b0, 8'h10, 32'h0, 4'h0);
    chk({rerr, rdat[30:0]}, 32'h80000000);
    xfer(1'b1, 8'h0c, 32'hff, 4'hf);
    chk(rerr, 32'h1);
    // Either standby halts every gated enable; register two reads back cleared
    for (i = 0; i < 2; i++) begin
      xfer(1'b1, 8'h00, 32'hff, 4'h1);
      xfer(1'b1, 8'h04, 32'hff, 4'h1);
      xfer(1'b1, 8'h08, 32'h1, 4'h1);
      @(posedge CLK_SYS);
      {SW_STANDBY, HW_STANDBY} <= 2'(1 << i);
      repeat (8) @(posedge CLK_SYS);
      chk({g1, RUN_CH_SEVEN, RUN_CH_SIX, RUN_CH_ELEVEN, RUN_CH_TEN_FREE}, 32'h1);
      {SW_STANDBY, HW_STANDBY} <= 2'b00;
      xfer(1'b0, 8'h04, 32'h0, 4'h0);
      chk(rdat, 32'h0);
    end
    // Reset in mid-run
    xfer(1'b1, 8'h00, 32'ha5, 4'h1);
    @(posedge CLK_SYS);
    SYS_RST <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    xfer(1'b0, 8'h00, 32'h0, 4'h0);
    chk({rdat[7:0], g1}, 32'h0);
    end_sim();
  end
endmodule // tb_top
